// file: design/mcu_memory_space_map.sv
/*
 * Address decode and control-pin logic of a small 8-bit core: program counter and
 * return stack, data-space decode with a read-only window onto program memory,
 * readout protection, boot-mode capture, falling-edge interrupt and port reset state.
 * Assumes a program memory with combinational read and a core that asks one
 * data access per cycle. All pin inputs are synchronous to core_clk_i.
 */
// What this block does
// - Program, data and stack spaces are three separate spaces, each with its own decode.
// - A 12-bit program counter addresses up to 4K bytes of program memory directly.
// - Program space holds code, immediate operands, a factory test area and the vectors.
// - The stack is six 12-bit registers saving return addresses of calls and interrupts.
// - With the protection option set, no external read returns program memory contents.
// - The protection flag is cleared by an erase of the whole program memory, or at boot when the protection option is not set.
// - The core reads program-memory constants through a 64-byte data-space window.
// - Data decode: RAM, window, accumulator, index, ports, peripherals, IOR, window select.
// - A falling edge on the interrupt pin raises the non-maskable interrupt.
// - The reset pin is active low, has top priority and cannot be masked.
// - The programming pin at high voltage during reset selects programming mode instead of run.
// - After reset every port pin is an input with pull-up until software changes it.
// - The timer pin is the timer's external input or its output, by configuration.
// - The window sits at data addresses 40h to 7Fh and maps one 64-byte program block.
// - The window select register keeps its value through reset; software sets it first.
// - Window select bits 5:0 give the upper program address bits; bits 7:6 are reserved.
`timescale 1ns/1ps
`default_nettype none

module mcu_memory_space_map #(
    parameter int STACK_DEPTH = mem_map_pkg::STACK_DEPTH
) (
    // Clock and the active-low reset pin.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Control pins and mode.
    input wire logic nmi_pin_i,
    input wire logic vpp_high_i,
    output logic nmi_req_o,
    output logic core_run_o,
    output logic prog_mode_o,
    // Program counter control from the core.
    input wire logic pc_step_i,
    input wire logic pc_jump_i,
    input wire logic pc_call_i,
    input wire logic pc_ret_i,
    input wire logic [11:0] pc_target_i,
    output logic [11:0] pc_o,
    output logic [$clog2(STACK_DEPTH+1)-1:0] stack_depth_o,
    // Program memory.
    output logic [11:0] prog_addr_o,
    input wire logic [7:0] prog_rdata_i,
    output logic fetch_stall_o,
    output logic mem_erase_o,
    // Core data-space access.
    input wire logic [7:0] data_addr_i,
    input wire logic data_rd_i,
    input wire logic data_wr_i,
    input wire logic [7:0] data_wdata_i,
    input wire logic [7:0] ext_rdata_i,
    output mem_map_pkg::region_t data_sel_o,
    output logic [7:0] data_rdata_o,
    output logic data_rvalid_o,
    // External readout and erase in programming mode.
    input wire logic ext_rd_i,
    input wire logic [11:0] ext_addr_i,
    input wire logic option_protect_i,
    input wire logic erase_all_i,
    output logic [7:0] ext_data_o,
    output logic ext_valid_o,
    output logic ext_blocked_o,
    // Port pins, three ports of eight.
    input wire logic [23:0] port_in_i,
    output logic [23:0] port_out_o,
    output logic [23:0] port_oe_o,
    output logic [23:0] port_pu_o,
    // Timer pin.
    input wire logic timer_pin_i,
    input wire logic timer_out_mode_i,
    input wire logic timer_drive_i,
    output logic timer_pin_o,
    output logic timer_pin_oe_o,
    output logic timer_ext_o
);
    typedef struct packed {
        mem_map_pkg::mode_t mode;
        logic nmi_prev;
        logic nmi_req;
        logic [11:0] pc;
        logic [5:0] wsel;
        logic prot;
        logic erase;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] xdata;
        logic xvalid;
        logic xblk;
        logic [23:0] dr;
        logic [23:0] ddr;
        logic [23:0] opt;
    } state_t;

    state_t r;
    state_t next_r;
    mem_map_pkg::region_t region;
    logic run;
    logic win_rd;
    logic push;
    logic pop;
    logic [11:0] stack_top;
    logic [1:0] pidx;
    logic [7:0] pin_rd;

    assign run = (r.mode == mem_map_pkg::MODE_RUN);
    assign pidx = data_addr_i[1:0];

    always_comb begin
        region = mem_map_pkg::REG_NONE;
        if (data_addr_i <= mem_map_pkg::RAM_LAST) begin
            region = mem_map_pkg::REG_RAM;
        end else if (data_addr_i <= mem_map_pkg::WIN_LAST) begin
            region = mem_map_pkg::REG_WINDOW;
        end else if (data_addr_i <= mem_map_pkg::CORE_IDX_LAST ||
                     data_addr_i == mem_map_pkg::ACC_ADDR) begin
            region = mem_map_pkg::REG_CORE;
        end else if (data_addr_i == mem_map_pkg::IOR_ADDR) begin
            region = mem_map_pkg::REG_IOR;
        end else if (data_addr_i == mem_map_pkg::WSEL_ADDR) begin
            region = mem_map_pkg::REG_WSEL;
        end else if ((data_addr_i[7:2] == mem_map_pkg::PORT_DR_BASE[7:2] ||
                      data_addr_i[7:2] == mem_map_pkg::PORT_DDR_BASE[7:2] ||
                      data_addr_i[7:2] == mem_map_pkg::PORT_OPT_BASE[7:2]) && pidx != 2'h3) begin
            region = mem_map_pkg::REG_PORT;
        end else if ((data_addr_i >= mem_map_pkg::PERIPH_BASE &&
                      data_addr_i <= mem_map_pkg::PERIPH_LAST) ||
                     data_addr_i == mem_map_pkg::WDG_ADDR) begin
            region = mem_map_pkg::REG_PERIPH;
        end
    end

    assign data_sel_o = region;
    assign win_rd = run && data_rd_i && region == mem_map_pkg::REG_WINDOW;

    // program space has its own source mux
    always_comb begin
        if (r.mode == mem_map_pkg::MODE_PROG) begin
            prog_addr_o = ext_addr_i;
        end else if (win_rd) begin
            prog_addr_o = {r.wsel, data_addr_i[mem_map_pkg::WIN_OFS_W-1:0]};
        end else begin
            prog_addr_o = r.pc;
        end
    end

    // The fetch loses the shared memory port to a window read, so the core waits one cycle.
    assign fetch_stall_o = !run || win_rd;

    assign push = run && pc_call_i && !pc_ret_i;
    assign pop = run && pc_ret_i;

    return_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(mem_map_pkg::PC_W)
    ) u_stack (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .push_i(push),
        .pop_i(pop),
        .push_data_i(r.pc),
        .top_o(stack_top),
        .depth_o(stack_depth_o),
        .full_o()
    );

    // Port data reads return the pin for inputs and the latch for outputs.
    assign pin_rd = (r.dr[pidx*8 +: 8] & r.ddr[pidx*8 +: 8]) |
                    (port_in_i[pidx*8 +: 8] & ~r.ddr[pidx*8 +: 8]);

    // Next-state logic for the whole block.
    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        next_r.xvalid = 1'b0;
        next_r.erase = 1'b0;
        next_r.nmi_prev = nmi_pin_i;
        next_r.nmi_req = r.nmi_prev && !nmi_pin_i;
        if (r.mode == mem_map_pkg::MODE_BOOT) begin
            next_r.mode = vpp_high_i ? mem_map_pkg::MODE_PROG : mem_map_pkg::MODE_RUN;
            next_r.prot = option_protect_i;
        end
        if (run) begin
            if (pc_ret_i) begin
                next_r.pc = stack_top;
            end else if (pc_call_i || pc_jump_i) begin
                next_r.pc = pc_target_i;
            end else if (pc_step_i) begin
                next_r.pc = r.pc + 12'h001;
            end
        end
        if (run && data_rd_i) begin
            next_r.rvalid = 1'b1;
            unique case (region)
                mem_map_pkg::REG_WINDOW: next_r.rdata = prog_rdata_i;
                mem_map_pkg::REG_WSEL: next_r.rdata = 8'h00;
                mem_map_pkg::REG_PORT: begin
                    if (data_addr_i[7:2] == mem_map_pkg::PORT_DR_BASE[7:2]) begin
                        next_r.rdata = pin_rd;
                    end else if (data_addr_i[7:2] == mem_map_pkg::PORT_DDR_BASE[7:2]) begin
                        next_r.rdata = r.ddr[pidx*8 +: 8];
                    end else begin
                        next_r.rdata = r.opt[pidx*8 +: 8];
                    end
                end
                default: next_r.rdata = ext_rdata_i;
            endcase
        end
        if (run && data_wr_i) begin
            if (region == mem_map_pkg::REG_WSEL) begin
                next_r.wsel = data_wdata_i[mem_map_pkg::WIN_SEL_W-1:0];
            end
            if (region == mem_map_pkg::REG_PORT) begin
                if (data_addr_i[7:2] == mem_map_pkg::PORT_DR_BASE[7:2]) begin
                    next_r.dr[pidx*8 +: 8] = data_wdata_i;
                end else if (data_addr_i[7:2] == mem_map_pkg::PORT_DDR_BASE[7:2]) begin
                    next_r.ddr[pidx*8 +: 8] = data_wdata_i;
                end else begin
                    next_r.opt[pidx*8 +: 8] = data_wdata_i;
                end
            end
        end
        if (r.mode == mem_map_pkg::MODE_PROG) begin
            if (ext_rd_i) begin
                next_r.xvalid = 1'b1;
                next_r.xblk = r.prot;
                next_r.xdata = r.prot ? mem_map_pkg::BLOCKED_DATA : prog_rdata_i;
            end
            if (erase_all_i) begin
                next_r.prot = 1'b0;
                next_r.erase = 1'b1;
            end else begin
                next_r.prot = r.prot | option_protect_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r.mode <= mem_map_pkg::MODE_BOOT;
            r.nmi_prev <= 1'b1;
            r.nmi_req <= 1'b0;
            r.pc <= mem_map_pkg::RESET_VECTOR;
            r.prot <= 1'b1;
            r.erase <= 1'b0;
            r.rdata <= 8'h00;
            r.rvalid <= 1'b0;
            r.xdata <= 8'h00;
            r.xvalid <= 1'b0;
            r.xblk <= 1'b0;
            r.dr <= {mem_map_pkg::NUM_PORTS{mem_map_pkg::PORT_RESET}};
            r.ddr <= {mem_map_pkg::NUM_PORTS{mem_map_pkg::PORT_RESET}};
            r.opt <= {mem_map_pkg::NUM_PORTS{mem_map_pkg::PORT_RESET}};
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from state; pull-up only on undriven, plain inputs.
    assign nmi_req_o = r.nmi_req;
    assign core_run_o = run;
    assign prog_mode_o = (r.mode == mem_map_pkg::MODE_PROG);
    assign pc_o = r.pc;
    assign mem_erase_o = r.erase;
    assign data_rdata_o = r.rdata;
    assign data_rvalid_o = r.rvalid;
    assign ext_data_o = r.xdata;
    assign ext_valid_o = r.xvalid;
    assign ext_blocked_o = r.xblk;
    assign port_out_o = r.dr;
    assign port_oe_o = r.ddr;
    assign port_pu_o = ~r.ddr & ~r.opt;

    assign timer_pin_oe_o = timer_out_mode_i;
    assign timer_pin_o = timer_drive_i;
    assign timer_ext_o = timer_pin_i & ~timer_out_mode_i;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    a_nmi_fall_pulse: assert property ($fell(nmi_pin_i) |=> nmi_req_o)
        else $error("Falling interrupt pin edge raised no request.");

    a_boot_mode_pick: assert property (r.mode == mem_map_pkg::MODE_BOOT |=>
        prog_mode_o == $past(vpp_high_i) && core_run_o == !$past(vpp_high_i))
        else $error("Boot mode does not follow the programming pin.");

    a_window_read_data: assert property (win_rd |=>
        data_rvalid_o && data_rdata_o == $past(prog_rdata_i))
        else $error("Window read did not return program memory data.");

    a_protect_blocks_read: assert property (prog_mode_o && ext_rd_i && r.prot |=>
        ext_valid_o && ext_blocked_o && ext_data_o == mem_map_pkg::BLOCKED_DATA)
        else $error("Protected readout leaked memory data.");

    a_erase_clears_prot: assert property (prog_mode_o && erase_all_i |=>
        mem_erase_o && !r.prot)
        else $error("Full erase did not clear protection.");

    a_call_then_return: assert property (push ##1 (run && pc_ret_i) |=>
        pc_o == $past(pc_o, 2))
        else $error("Return did not restore the calling address.");

    c_window_read: cover property (win_rd ##1 data_rvalid_o);
    c_prog_blocked: cover property (prog_mode_o && ext_rd_i && r.prot);
    c_stack_full_push: cover property (push &&
        stack_depth_o == ($clog2(STACK_DEPTH+1))'(STACK_DEPTH));

endmodule

`default_nettype wire

// file: inc/mem_map_pkg.sv
/*
 * Shared constants and types for the memory-space decoder of a small 8-bit core:
 * data-space offsets, window layout, reset values and mode enumerations.
 * Assumes an 8-bit data space, a 12-bit program space and one core clock.
 */
package mem_map_pkg;

    // Program space and stack geometry.
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 6;
    localparam logic [11:0] RESET_VECTOR = 12'hffe;

    // Data-space layout; every region is a byte address in the 8-bit data space.
    localparam int DATA_AW = 8;
    localparam logic [7:0] RAM_BASE = 8'h00;
    localparam logic [7:0] RAM_LAST = 8'h3f;
    localparam logic [7:0] WIN_BASE = 8'h40;
    localparam logic [7:0] WIN_LAST = 8'h7f;
    localparam logic [7:0] CORE_IDX_BASE = 8'h80;
    localparam logic [7:0] CORE_IDX_LAST = 8'h83;
    localparam logic [7:0] ACC_ADDR = 8'hff;
    localparam logic [7:0] PORT_DR_BASE = 8'hc0;
    localparam logic [7:0] PORT_DDR_BASE = 8'hc4;
    localparam logic [7:0] PORT_OPT_BASE = 8'hcc;
    localparam logic [7:0] IOR_ADDR = 8'hc8;
    localparam logic [7:0] WSEL_ADDR = 8'hc9;
    localparam logic [7:0] PERIPH_BASE = 8'hd0;
    localparam logic [7:0] PERIPH_LAST = 8'hd4;
    localparam logic [7:0] WDG_ADDR = 8'hd8;

    // Window select layout: low six bits form the block number.
    localparam int WIN_SEL_W = 6;
    localparam int WIN_OFS_W = 6;

    // Port geometry and reset values.
    localparam int NUM_PORTS = 3;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] BLOCKED_DATA = 8'h00;

    // Operating mode chosen at the release of reset.
    typedef enum logic [1:0] {
        MODE_BOOT,
        MODE_RUN,
        MODE_PROG
    } mode_t;

    // Data-space region selected by the current core address.
    typedef enum logic [2:0] {
        REG_NONE,
        REG_RAM,
        REG_WINDOW,
        REG_CORE,
        REG_PORT,
        REG_PERIPH,
        REG_IOR,
        REG_WSEL
    } region_t;

endpackage

// file: design/return_stack.sv
/*
 * Hardware return-address stack of fixed depth, built as a shift register.
 * Assumes the caller never pushes and pops in the same cycle; a push wins.
 */
`timescale 1ns/1ps
`default_nettype none

module return_stack #(
    parameter int DEPTH = mem_map_pkg::STACK_DEPTH,
    parameter int WIDTH = mem_map_pkg::PC_W
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Push and pop requests.
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [WIDTH-1:0] push_data_i,
    // Stack view.
    output logic [WIDTH-1:0] top_o,
    output logic [$clog2(DEPTH+1)-1:0] depth_o,
    output logic full_o
);
    localparam int DW = $clog2(DEPTH + 1);
    localparam logic [DW-1:0] FULL = DW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] ent;
        logic [DW-1:0] depth;
    } stk_t;

    stk_t r;
    stk_t next_r;

    // Entry 0 is the top; a push onto a full stack lets the oldest entry fall off silently.
    always_comb begin
        next_r = r;
        if (push_i) begin
            next_r.ent = {r.ent[DEPTH-2:0], push_data_i};
            if (r.depth != FULL) begin
                next_r.depth = r.depth + 1'b1;
            end
        end else if (pop_i) begin
            next_r.ent = {r.ent[DEPTH-1], r.ent[DEPTH-1:1]};
            if (r.depth != '0) begin
                next_r.depth = r.depth - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign top_o = r.ent[0];
    assign depth_o = r.depth;
    assign full_o = (r.depth == FULL);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    a_push_top_value: assert property (push_i |=> top_o == $past(push_data_i))
        else $error("Pushed address is not on top of the stack.");

    a_full_drop_depth: assert property (push_i && full_o |=> full_o && depth_o == FULL)
        else $error("Push onto a full stack changed its depth.");

    a_pop_restores: assert property (push_i ##1 (pop_i && !push_i) |=>
        top_o == $past(top_o, 2))
        else $error("Pop did not restore the previous top.");

endmodule

`default_nettype wire

// file: tb/prog_mem_model.sv
/*
 * Behavioural program memory that stands behind the decoder's memory port.
 * Assumes a combinational read and an erase pulse that is synchronous to core_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module prog_mem_model (
    // Clock.
    input wire logic core_clk_i,
    // Memory port of the decoder.
    input wire logic [11:0] prog_addr_i,
    input wire logic mem_erase_i,
    output logic [7:0] prog_rdata_o
);
    logic erased = 1'b0;

    // whole array erase: one pulse blanks every byte at once, never part of it.
    always @(posedge core_clk_i) begin
        if (mem_erase_i === 1'b1) begin
            erased <= 1'b1;
        end
    end

    // full reach: each of the 4K bytes holds a pattern tied to its address.
    // The pattern mixes high and low address bits, so a wrong block number shows up.
    assign prog_rdata_o = erased ? 8'hff : (prog_addr_i[7:0] ^ {prog_addr_i[11:8], 4'h9});
endmodule

`default_nettype wire

// file: tb/tb.sv
/*
 * Self-checking testbench of the memory-space decoder, one task per scenario.
 * Assumes the program memory model beside it and a 25 MHz core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic nmi_pin_i = 1'b1;
    logic vpp_high_i = 1'b0;
    logic pc_step_i = 1'b0;
    logic pc_jump_i = 1'b0;
    logic pc_call_i = 1'b0;
    logic pc_ret_i = 1'b0;
    logic [11:0] pc_target_i = 12'h000;
    logic [7:0] data_addr_i = 8'h00;
    logic data_rd_i = 1'b0;
    logic data_wr_i = 1'b0;
    logic [7:0] data_wdata_i = 8'h00;
    logic [7:0] ext_rdata_i = 8'h3e;
    logic ext_rd_i = 1'b0;
    logic [11:0] ext_addr_i = 12'h000;
    logic option_protect_i = 1'b0;
    logic erase_all_i = 1'b0;
    logic [23:0] port_in_i = 24'h3ca50f;
    logic timer_pin_i = 1'b0;
    logic timer_out_mode_i = 1'b0;
    logic timer_drive_i = 1'b0;
    logic nmi_req_o, core_run_o, prog_mode_o, fetch_stall_o, mem_erase_o;
    logic data_rvalid_o, ext_valid_o, ext_blocked_o;
    logic timer_pin_o, timer_pin_oe_o, timer_ext_o;
    logic [11:0] pc_o, prog_addr_o;
    logic [2:0] stack_depth_o;
    logic [7:0] prog_rdata_i, data_rdata_o, ext_data_o;
    logic [23:0] port_out_o, port_oe_o, port_pu_o;
    mem_map_pkg::region_t data_sel_o;
    int miscompares = 0;
    int checks = 0;

    // Half period of 20 ns gives the 40 ns core clock.
    always #20 core_clk_i = ~core_clk_i;

    mcu_memory_space_map i_mcu_memory_space_map (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .nmi_pin_i(nmi_pin_i), .vpp_high_i(vpp_high_i), .nmi_req_o(nmi_req_o),
        .core_run_o(core_run_o), .prog_mode_o(prog_mode_o), .pc_step_i(pc_step_i),
        .pc_jump_i(pc_jump_i), .pc_call_i(pc_call_i), .pc_ret_i(pc_ret_i),
        .pc_target_i(pc_target_i), .pc_o(pc_o), .stack_depth_o(stack_depth_o),
        .prog_addr_o(prog_addr_o), .prog_rdata_i(prog_rdata_i), .fetch_stall_o(fetch_stall_o),
        .mem_erase_o(mem_erase_o), .data_addr_i(data_addr_i), .data_rd_i(data_rd_i),
        .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i), .ext_rdata_i(ext_rdata_i),
        .data_sel_o(data_sel_o), .data_rdata_o(data_rdata_o), .data_rvalid_o(data_rvalid_o),
        .ext_rd_i(ext_rd_i), .ext_addr_i(ext_addr_i), .option_protect_i(option_protect_i),
        .erase_all_i(erase_all_i), .ext_data_o(ext_data_o), .ext_valid_o(ext_valid_o),
        .ext_blocked_o(ext_blocked_o), .port_in_i(port_in_i), .port_out_o(port_out_o),
        .port_oe_o(port_oe_o), .port_pu_o(port_pu_o), .timer_pin_i(timer_pin_i),
        .timer_out_mode_i(timer_out_mode_i), .timer_drive_i(timer_drive_i),
        .timer_pin_o(timer_pin_o), .timer_pin_oe_o(timer_pin_oe_o), .timer_ext_o(timer_ext_o));

    prog_mem_model i_prog_mem_model (.core_clk_i(core_clk_i), .prog_addr_i(prog_addr_o),
        .mem_erase_i(mem_erase_o), .prog_rdata_o(prog_rdata_i));

    // Expected memory byte, written out independently of the model.
    function automatic logic [7:0] exp_mem(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h9};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset pulse of three cycles; the mode pin is set up while reset is low.
    task automatic do_reset(input logic vpp);
        @(posedge core_clk_i);
        arst_n_i <= 1'b0;
        vpp_high_i <= vpp;
        option_protect_i <= vpp;
        repeat (3) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        data_addr_i <= a;
        data_wdata_i <= d;
        data_wr_i <= 1'b1;
        @(posedge core_clk_i);
        data_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        data_addr_i <= a;
        data_rd_i <= 1'b1;
        @(posedge core_clk_i);
        data_rd_i <= 1'b0;
        @(negedge core_clk_i);
        check(data_rvalid_o, 1'b1, "read answer");
        d = data_rdata_o;
    endtask

    task automatic ext_read(input logic [11:0] a);
        @(posedge core_clk_i);
        ext_rd_i <= 1'b1;
        ext_addr_i <= a;
        @(posedge core_clk_i);
        ext_rd_i <= 1'b0;
        @(negedge core_clk_i);
        check(ext_valid_o, 1'b1, "readout answer");
    endtask

    task automatic t_reset_state;
        check(pc_o, 12'hffe, "start address");
        check(core_run_o, 1'b1, "run after reset");
        check(port_oe_o, 24'h000000, "ports are inputs");
        check(port_pu_o, 24'hffffff, "pull-ups on");
    endtask

    task automatic t_regions;
        logic [7:0] a [10] = '{8'h00, 8'h3f, 8'h40, 8'h80, 8'hff, 8'hc0, 8'hc8, 8'hc9,
            8'hd0, 8'hc3};
        mem_map_pkg::region_t r [10] = '{mem_map_pkg::REG_RAM, mem_map_pkg::REG_RAM,
            mem_map_pkg::REG_WINDOW, mem_map_pkg::REG_CORE, mem_map_pkg::REG_CORE,
            mem_map_pkg::REG_PORT, mem_map_pkg::REG_IOR, mem_map_pkg::REG_WSEL,
            mem_map_pkg::REG_PERIPH, mem_map_pkg::REG_NONE};
        logic [7:0] d;
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk_i);
            data_addr_i <= a[i];
            @(negedge core_clk_i);
            check(32'(data_sel_o), 32'(r[i]), "region decode");
        end
        rd(8'h10, d);
        check(d, 8'h3e, "outside region data");
    endtask

    task automatic t_window;
        logic [7:0] d;
        wr(mem_map_pkg::WSEL_ADDR, 8'hc5);
        @(posedge core_clk_i);
        data_addr_i <= 8'h40;
        data_rd_i <= 1'b1;
        @(negedge core_clk_i);
        check(prog_addr_o, 12'h140, "window address low");
        check(fetch_stall_o, 1'b1, "window owns memory");
        @(posedge core_clk_i);
        data_addr_i <= 8'h7f;
        @(negedge core_clk_i);
        check(data_rdata_o, exp_mem(12'h140), "window byte low");
        check(prog_addr_o, 12'h17f, "window address high");
        @(posedge core_clk_i);
        data_rd_i <= 1'b0;
        @(negedge core_clk_i);
        check(data_rdata_o, exp_mem(12'h17f), "window byte high");
        rd(mem_map_pkg::WSEL_ADDR, d);
        check(d, 8'h00, "select is write only");
    endtask

    task automatic t_ports;
        logic [7:0] d;
        wr(mem_map_pkg::PORT_DDR_BASE, 8'hff);
        wr(mem_map_pkg::PORT_DR_BASE, 8'h5a);
        wr(mem_map_pkg::PORT_OPT_BASE + 8'h01, 8'hff);
        @(negedge core_clk_i);
        check(port_oe_o, 24'h0000ff, "port A output");
        check(port_out_o[7:0], 8'h5a, "port A latch");
        check(port_pu_o, 24'hff0000, "pull-ups after change");
        rd(mem_map_pkg::PORT_DR_BASE, d);
        check(d, 8'h5a, "output port reads latch");
        rd(mem_map_pkg::PORT_DR_BASE + 8'h01, d);
        check(d, 8'ha5, "input port reads pins");
    endtask

    task automatic t_stack;
        @(posedge core_clk_i);
        pc_jump_i <= 1'b1;
        pc_target_i <= 12'h0ab;
        @(posedge core_clk_i);
        pc_jump_i <= 1'b0;
        pc_step_i <= 1'b1;
        @(posedge core_clk_i);
        pc_step_i <= 1'b0;
        @(negedge core_clk_i);
        check(pc_o, 12'h0ac, "jump then step");
        // Seven calls: the first return address must fall off the bottom.
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk_i);
            pc_call_i <= 1'b1;
            pc_target_i <= 12'h100 + 12'(i);
        end
        @(posedge core_clk_i);
        pc_call_i <= 1'b0;
        pc_ret_i <= 1'b1;
        @(negedge core_clk_i);
        check(stack_depth_o, 3'd6, "stack full");
        check(pc_o, 12'h106, "last call target");
        for (int i = 5; i >= 0; i--) begin
            @(posedge core_clk_i);
            if (i == 0) begin
                pc_ret_i <= 1'b0;
            end
            @(negedge core_clk_i);
            check(pc_o, 12'h100 + 12'(i), "return address");
        end
        check(stack_depth_o, 3'd0, "stack empty");
    endtask

    task automatic t_nmi;
        int n;
        n = 0;
        @(posedge core_clk_i);
        nmi_pin_i <= 1'b0;
        repeat (6) begin
            @(negedge core_clk_i);
            n += (nmi_req_o === 1'b1) ? 1 : 0;
        end
        @(posedge core_clk_i);
        nmi_pin_i <= 1'b1;
        repeat (4) begin
            @(negedge core_clk_i);
            n += (nmi_req_o === 1'b1) ? 1 : 0;
        end
        check(n, 1, "one request per falling edge");
    endtask

    task automatic t_timer;
        @(posedge core_clk_i);
        timer_out_mode_i <= 1'b1;
        timer_drive_i <= 1'b1;
        @(negedge core_clk_i);
        check({timer_pin_oe_o, timer_pin_o}, 2'b11, "timer pin drives");
        @(posedge core_clk_i);
        timer_out_mode_i <= 1'b0;
        timer_pin_i <= 1'b1;
        @(negedge core_clk_i);
        check({timer_pin_oe_o, timer_ext_o}, 2'b01, "timer pin senses");
    endtask

    // A reset in mid-run must leave the window select as it was.
    task automatic t_keep_window;
        logic [7:0] d;
        do_reset(1'b0);
        rd(8'h41, d);
        check(d, exp_mem(12'h141), "window kept over reset");
    endtask

    task automatic t_protect;
        do_reset(1'b1);
        check({prog_mode_o, core_run_o}, 2'b10, "programming mode");
        ext_read(12'h123);
        check({ext_blocked_o, ext_data_o}, 9'h100, "protected readout");
        @(posedge core_clk_i);
        option_protect_i <= 1'b0;
        erase_all_i <= 1'b1;
        @(posedge core_clk_i);
        erase_all_i <= 1'b0;
        @(negedge core_clk_i);
        check(mem_erase_o, 1'b1, "erase command");
        ext_read(12'h123);
        check({ext_blocked_o, ext_data_o}, 9'h0ff, "blank after erase");
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles.
    initial begin
        #(2000 * 40);
        miscompares++;
        end_of_test();
    end

    initial begin
        do_reset(1'b0);
        t_reset_state();
        t_regions();
        t_window();
        t_ports();
        t_stack();
        t_nmi();
        t_timer();
        t_keep_window();
        t_protect();
        end_of_test();
    end
endmodule

`default_nettype wire
